//--- sfdp_basic_param_rom.sv
// Basic flash parameter table words two to seven, read over AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module sfdp_basic_param_rom
    import sfdp_param_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic enhanced_latency_table;
    logic [7:0] table_write_count;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Table words built from their fields
    wire [7:0] qio_timing = {QIO_MODE_CYC, QIO_DUMMY_CYC};
    wire [7:0] qout_timing = {QOUT_MODE_CYC, QOUT_DUMMY_CYC};
    wire [7:0] dout_timing = {DOUT_MODE_CYC, DOUT_DUMMY_CYC};
    wire [7:0] dio_timing = enhanced_latency_table ?
        {DIO_ENH_MODE_CYC, DIO_ENH_DUMMY_CYC} :
        {DIO_STD_MODE_CYC, DIO_STD_DUMMY_CYC};
    wire [7:0] support_byte = {RSVD_HI_BITS, QUAD_ALL_SUPPORTED,
        RSVD_MID_BITS, DUAL_ALL_SUPPORTED};
    wire [7:0] dall_timing = {DALL_MODE_CYC, DALL_DUMMY_CYC};
    wire [31:0] density_word = DENSITY_VALUE;
    wire [31:0] quad_read_params_word = {QOUT_OPCODE, qout_timing,
        QIO_OPCODE, qio_timing};
    wire [31:0] dual_read_params_word = {DIO_OPCODE, dio_timing,
        DOUT_OPCODE, dout_timing};
    wire [31:0] all_mode_support_word = {RSVD_BYTE, RSVD_BYTE, RSVD_BYTE,
        support_byte};
    wire [31:0] dual_all_params_word = {DALL_OPCODE, dall_timing,
        RSVD_BYTE, RSVD_BYTE};
    wire [31:0] quad_all_params_word = {QALL_FIELD_BYTE, RSVD_BYTE,
        RSVD_BYTE, RSVD_BYTE};

    // Read decode, word aligned
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
    wire rd_table = (rd_addr == OFS_DENSITY) || (rd_addr == OFS_QUAD_READ) ||
        (rd_addr == OFS_DUAL_READ) || (rd_addr == OFS_ALL_SUPPORT) ||
        (rd_addr == OFS_DUAL_ALL) || (rd_addr == OFS_QUAD_ALL);
    wire rd_hit = rd_table || (rd_addr == OFS_CTRL) || (rd_addr == OFS_STATUS);
    wire [31:0] rd_word =
        (rd_addr == OFS_DENSITY) ? density_word :
        (rd_addr == OFS_QUAD_READ) ? quad_read_params_word :
        (rd_addr == OFS_DUAL_READ) ? dual_read_params_word :
        (rd_addr == OFS_ALL_SUPPORT) ? all_mode_support_word :
        (rd_addr == OFS_DUAL_ALL) ? dual_all_params_word :
        (rd_addr == OFS_QUAD_ALL) ? quad_all_params_word :
        (rd_addr == OFS_CTRL) ? {31'h0000_0000, enhanced_latency_table} :
        (rd_addr == OFS_STATUS) ? {24'h00_0000, table_write_count} :
        DATA_ZERO;

    // Read channel handshakes
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_hs = s_axi_arvalid && s_axi_arready;

    // Write channel handshakes; address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire do_write = (aw_held || aw_hs) && (w_held || w_hs) && !s_axi_bvalid;
    wire [7:0] wr_addr_raw = aw_held ? aw_addr_q : s_axi_awaddr;
    wire [7:0] wr_addr = {wr_addr_raw[7:2], 2'b00};
    wire [31:0] wr_data = w_held ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb_q : s_axi_wstrb;
    wire wr_table = (wr_addr == OFS_DENSITY) || (wr_addr == OFS_QUAD_READ) ||
        (wr_addr == OFS_DUAL_READ) || (wr_addr == OFS_ALL_SUPPORT) ||
        (wr_addr == OFS_DUAL_ALL) || (wr_addr == OFS_QUAD_ALL);
    wire wr_ctrl = wr_addr == OFS_CTRL;
    wire wr_hit = wr_table || wr_ctrl || (wr_addr == OFS_STATUS);
    wire table_write_sat = &table_write_count;

    // Read answer, one cycle after the address is taken
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= DATA_ZERO;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Hold whichever of address and data arrives first
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= DATA_ZERO;
            w_strb_q <= 4'h0;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response after both halves are in
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Latency table select, and count of table writes that were ignored
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enhanced_latency_table <= CTRL_ENH_RESET;
            table_write_count <= STATUS_CNT_RESET;
        end
        else if (do_write)
        begin
            if (wr_ctrl && wr_strb[0])
            begin
                enhanced_latency_table <= wr_data[CTRL_ENH_BIT];
            end
            if (wr_table && !table_write_sat)
            begin
                table_write_count <= table_write_count + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

//--- sfdp_param_pkg.sv
// Constants, offsets and field layouts of the basic flash parameter table block
// Summary of operation
// - Density word reads total bits minus one, bytes FFh FFh FFh 1Fh.
// - Byte 08h gives two quad-I/O mode cycles, four dummy cycles: 44h.
// - Byte 09h holds the quad-I/O read opcode EBh.
// - Byte 0Ah gives zero quad-output mode cycles, eight dummy cycles: 08h.
// - Byte 0Bh holds the quad-output read opcode 6Bh.
// - Byte 0Ch gives zero dual-output mode cycles, eight dummy cycles: 08h.
// - Byte 0Dh holds the dual-output read opcode 3Bh.
// - Byte 0Eh reads 04h for standard latency table, 80h for enhanced.
// - Byte 0Fh holds the dual-I/O read opcode BBh.
// - Byte 10h reads EEh: all-quad and all-dual flagged unsupported.
// - Byte 16h reads FFh: all-dual mode and dummy fields all ones.
// - Byte 17h, the all-dual opcode slot, reads FFh.
// - Reserved bytes 11h to 15h and 18h to 1Ah read FFh.
// - Byte 1Bh, the all-quad opcode slot, reads EBh.
package sfdp_param_pkg;

    // Byte addresses on the register bus
    localparam logic [7:0] OFS_DENSITY = 8'h04;
    localparam logic [7:0] OFS_QUAD_READ = 8'h08;
    localparam logic [7:0] OFS_DUAL_READ = 8'h0C;
    localparam logic [7:0] OFS_ALL_SUPPORT = 8'h10;
    localparam logic [7:0] OFS_DUAL_ALL = 8'h14;
    localparam logic [7:0] OFS_QUAD_ALL = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // Control and status register fields
    localparam int CTRL_ENH_BIT = 0;
    localparam logic CTRL_ENH_RESET = 1'b0;
    localparam logic [7:0] STATUS_CNT_RESET = 8'h00;

    // Density, zero based
    localparam logic [31:0] DENSITY_VALUE = 32'h1FFF_FFFF;

    // Quad-I/O read timing and opcode
    localparam logic [2:0] QIO_MODE_CYC = 3'h2;
    localparam logic [4:0] QIO_DUMMY_CYC = 5'h04;
    localparam logic [7:0] QIO_OPCODE = 8'hEB;

    // Quad-output read timing and opcode
    localparam logic [2:0] QOUT_MODE_CYC = 3'h0;
    localparam logic [4:0] QOUT_DUMMY_CYC = 5'h08;
    localparam logic [7:0] QOUT_OPCODE = 8'h6B;

    // Dual-output read timing and opcode
    localparam logic [2:0] DOUT_MODE_CYC = 3'h0;
    localparam logic [4:0] DOUT_DUMMY_CYC = 5'h08;
    localparam logic [7:0] DOUT_OPCODE = 8'h3B;

    // Dual-I/O read timing per latency table variant, and opcode
    localparam logic [2:0] DIO_STD_MODE_CYC = 3'h0;
    localparam logic [4:0] DIO_STD_DUMMY_CYC = 5'h04;
    localparam logic [2:0] DIO_ENH_MODE_CYC = 3'h4;
    localparam logic [4:0] DIO_ENH_DUMMY_CYC = 5'h00;
    localparam logic [7:0] DIO_OPCODE = 8'hBB;

    // All-mode support flags and reserved bytes
    localparam logic [2:0] RSVD_HI_BITS = 3'h7;
    localparam logic [2:0] RSVD_MID_BITS = 3'h7;
    localparam logic QUAD_ALL_SUPPORTED = 1'b0;
    localparam logic DUAL_ALL_SUPPORTED = 1'b0;
    localparam logic [7:0] RSVD_BYTE = 8'hFF;

    // All-dual and all-quad fields
    localparam logic [2:0] DALL_MODE_CYC = 3'h7;
    localparam logic [4:0] DALL_DUMMY_CYC = 5'h1F;
    localparam logic [7:0] DALL_OPCODE = 8'hFF;
    localparam logic [7:0] QALL_FIELD_BYTE = 8'hEB;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

//--- sfdp_rom_monitor.sv
// Assertion checker for the parameter table read channel
`timescale 1ns/100ps
`default_nettype none
module sfdp_rom_checker
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Read request taken, its address, the answer and an OKAY flag
    wire tk = s_axi_arvalid && s_axi_arready;
    wire [7:0] a = s_axi_araddr;
    wire [31:0] d = s_axi_rdata;
    wire ok = (s_axi_rresp == 2'h0);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_RD_LAT: assert property (tk |=> s_axi_rvalid)
        else $error("read answer not one cycle after request");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(d))
        else $error("read answer dropped or changed before taken");
    AST_DENS: assert property (tk && a == 8'h04 |=> d == 32'h1FFF_FFFF && ok)
        else $error("density word wrong");
    AST_QUAD: assert property (tk && a == 8'h08 |=> d == 32'h6B08_EB44 && ok)
        else $error("quad read word wrong");
    AST_DUAL: assert property (tk && a == 8'h0C |=> ok && (d == 32'hBB04_3B08 || d == 32'hBB80_3B08))
        else $error("dual read word wrong");
    AST_SUPP: assert property (tk && a == 8'h10 |=> d == 32'hFFFF_FFEE && ok)
        else $error("mode support word wrong");
    AST_DALL: assert property (tk && a == 8'h14 |=> d == 32'hFFFF_FFFF && ok)
        else $error("all-dual word wrong");
    AST_QALL: assert property (tk && a == 8'h18 |=> d == 32'hEBFF_FFFF && ok)
        else $error("all-quad word wrong");
endmodule
bind sfdp_basic_param_rom sfdp_rom_checker chk_i (.clk_sys, .arst_n, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- axil_host_model.sv
// Register bus master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module axil_host_model
(
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus at time zero
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    end
    // One transfer; each channel held until its own ready, answer taken with its valid
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] v,
        output logic [31:0] d, output logic [1:0] r);
        logic done;
        @(posedge clk_sys);
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
        {s_axi_arvalid, s_axi_rready} <= {2{!we}};
        while (!done)
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (we ? s_axi_bvalid : s_axi_rvalid)
            begin
                done = 1'b1;
                d = s_axi_rdata;
                r = we ? s_axi_bresp : s_axi_rresp;
                {s_axi_bready, s_axi_rready} <= 2'h0;
            end
        end
    endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the parameter table block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys;
    logic arst_n;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] tbl [6] = '{32'h1FFF_FFFF, 32'h6B08_EB44, 32'hBB04_3B08, 32'hFFFF_FFEE,
        32'hFFFF_FFFF, 32'hEBFF_FFFF};
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [2:0] s_axi_awprot = 3'h0;
    wire [2:0] s_axi_arprot = 3'h0;
    wire [3:0] s_axi_wstrb = 4'hF;
    // Block under test and the host in front of it
    sfdp_basic_param_rom uut (.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    axil_host_model host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, want);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // 50 ns clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end
    // Table read ascending, written over, read again; then variant, status and unmapped
    initial
    begin
        arst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            host.xfer(1'b0, 8'(4 * i + 4), 32'h0000_0000, d, r);
            chk(d, tbl[i]);
            chk({30'h0, r}, 32'h0000_0000);
            host.xfer(1'b1, 8'(4 * i + 4), ~tbl[i], d, r);
            chk({30'h0, r}, 32'h0000_0000);
            host.xfer(1'b0, 8'(4 * i + 4), 32'h0000_0000, d, r);
            chk(d, tbl[i]);
        end
        host.xfer(1'b1, 8'h20, 32'h0000_0001, d, r);
        chk({30'h0, r}, 32'h0000_0000);
        host.xfer(1'b0, 8'h20, 32'h0000_0000, d, r);
        chk(d, 32'h0000_0001);
        host.xfer(1'b0, 8'h0C, 32'h0000_0000, d, r);
        chk(d, 32'hBB80_3B08);
        host.xfer(1'b1, 8'h20, 32'h0000_0000, d, r);
        host.xfer(1'b0, 8'h0C, 32'h0000_0000, d, r);
        chk(d, 32'hBB04_3B08);
        host.xfer(1'b0, 8'h24, 32'h0000_0000, d, r);
        chk(d, 32'h0000_0006);
        host.xfer(1'b0, 8'h1C, 32'h0000_0000, d, r);
        chk({d[29:0], r}, 32'h0000_0002);
        host.xfer(1'b1, 8'h00, 32'h0000_0000, d, r);
        chk({30'h0, r}, 32'h0000_0002);
        results();
    end
endmodule
`default_nettype wire
